// >>> src/asm_slot_mapper.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module asm_slot_mapper
    import asm_pkg::*;
#(
    parameter int CHANNELS = ASM_NUM_CHANNELS
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_sys_rst,
    input  wire logic [ASM_ADDR_WIDTH-1:0] i_addr,
    input  wire logic [ASM_DATA_WIDTH-1:0] i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [ASM_DATA_WIDTH-1:0] o_rdata,
    input  wire asm_slot_pos_t             i_slot,
    input  wire logic [CHANNELS-1:0]       i_chan_bits,
    output logic                           o_primary_serial_out,
    output logic                           o_primary_serial_oe,
    output logic                           o_general_pin_one_out,
    output logic                           o_general_pin_one_oe,
    output logic      [CHANNELS-1:0]       o_chan_active,
    output logic                           o_collision
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The register map only holds three channel registers
    if (CHANNELS < 1 || CHANNELS > ASM_NUM_CHANNELS) begin : g_bad_channels
        $error("asm_slot_mapper: CHANNELS must be 1 to 3");
    end

    // ************************************************************
    // Channel configuration registers
    // ************************************************************
    asm_chan_cfg_t [CHANNELS-1:0] chan_cfg;
    logic          [CHANNELS-1:0] hit_primary;
    logic          [CHANNELS-1:0] hit_secondary;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        // One register per channel; bit 7 has no storage so it can never be set
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                chan_cfg[ch] <= asm_chan_cfg_t'(ASM_CHAN_RESETS[ch][ASM_LINE_SEL_BIT:0]);
            end else if (i_wr && (i_addr == ASM_CHAN_ADDRS[ch])) begin
                chan_cfg[ch] <= asm_chan_cfg_t'(i_wdata[ASM_LINE_SEL_BIT:0]);
            end
        end

        // Slot compare for this channel against the live position
        asm_slot_lane u_lane (
            .i_cfg           (chan_cfg[ch]),
            .i_pos           (i_slot),
            .o_hit_primary   (hit_primary[ch]),
            .o_hit_secondary (hit_secondary[ch])
        );
    end

    // ************************************************************
    // Line combining
    // ************************************************************
    asm_line_drive_t next_primary;
    asm_line_drive_t next_secondary;
    logic            next_clash;

    // Two channels in one slot of one line is a setup error; their bits are ORed
    // rather than one silently winning, and the clash is flagged for software
    always_comb begin
        next_primary.enable   = |hit_primary;
        next_primary.data     = |(hit_primary & i_chan_bits);
        next_secondary.enable = |hit_secondary;
        next_secondary.data   = |(hit_secondary & i_chan_bits);
        next_clash            = ($countones(hit_primary) > 1) || ($countones(hit_secondary) > 1);
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Registered so the pins change on one clean edge; costs one cycle of latency
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_primary_serial_out  <= 1'b0;
            o_primary_serial_oe   <= 1'b0;
            o_general_pin_one_out <= 1'b0;
            o_general_pin_one_oe  <= 1'b0;
        end else begin
            o_primary_serial_out  <= next_primary.data;
            o_primary_serial_oe   <= next_primary.enable;
            o_general_pin_one_out <= next_secondary.data;
            o_general_pin_one_oe  <= next_secondary.enable;
        end
    end

    // Which channels own the current slot, on either line
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_chan_active <= '0;
        end else begin
            o_chan_active <= hit_primary | hit_secondary;
        end
    end

    // ************************************************************
    // Clash flag
    // ************************************************************
    logic clear_clash;

    assign clear_clash = i_wr && (i_addr == ASM_ADDR_STATUS) && i_wdata[ASM_STAT_COLL_BIT];

    // Sticky; a clash in the clearing cycle wins so it is never lost
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_collision <= 1'b0;
        end else if (next_clash) begin
            o_collision <= 1'b1;
        end else if (clear_clash) begin
            o_collision <= 1'b0;
        end
    end

    // ************************************************************
    // Register read
    // ************************************************************
    logic [ASM_DATA_WIDTH-1:0] next_rdata;

    // Unmapped addresses read zero; bit 7 of a channel register always reads zero
    always_comb begin
        next_rdata = ASM_READ_IDLE;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            if (i_addr == ASM_CHAN_ADDRS[ch]) begin
                next_rdata = {1'b0, chan_cfg[ch]};
            end
        end
        if (i_addr == ASM_ADDR_STATUS) begin
            next_rdata[ASM_STAT_COLL_BIT] = o_collision;
            next_rdata[CHANNELS-1:0]      = o_chan_active;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= ASM_READ_IDLE;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= ASM_READ_IDLE;
        end
    end

endmodule // asm_slot_mapper

// >>> src/asm_pkg.sv
package asm_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ASM_NUM_CHANNELS = 3;
    localparam int ASM_DATA_WIDTH   = 8;
    localparam int ASM_ADDR_WIDTH   = 8;
    localparam int ASM_SLOT_WIDTH   = 6;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ASM_ADDR_CH1    = 8'h0B;
    localparam logic [7:0] ASM_ADDR_CH2    = 8'h0C;
    localparam logic [7:0] ASM_ADDR_CH3    = 8'h0D;
    localparam logic [7:0] ASM_ADDR_STATUS = 8'h11;
    // Channel registers indexed by channel number minus one
    localparam logic [2:0][7:0] ASM_CHAN_ADDRS = {ASM_ADDR_CH3, ASM_ADDR_CH2, ASM_ADDR_CH1};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ASM_RSVD_BIT      = 7;
    localparam int ASM_LINE_SEL_BIT  = 6;
    localparam int ASM_SLOT_MSB      = 5;
    localparam int ASM_HALF_BIT      = 5;
    localparam int ASM_STAT_COLL_BIT = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] ASM_CH1_RESET = 8'h00;
    localparam logic [7:0] ASM_CH2_RESET = 8'h01;
    localparam logic [7:0] ASM_CH3_RESET = 8'h02;
    localparam logic [2:0][7:0] ASM_CHAN_RESETS = {ASM_CH3_RESET, ASM_CH2_RESET, ASM_CH1_RESET};
    localparam logic [7:0] ASM_READ_IDLE = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic                      line_sel;   // 0 primary, 1 secondary
        logic [ASM_SLOT_WIDTH-1:0] slot_index;
    } asm_chan_cfg_t;

    typedef struct packed {
        logic                      valid;      // A bit of a slot is on the line
        logic                      tdm;        // 1 TDM, 0 I2S or left justified
        logic                      right_half; // Only read outside TDM
        logic [ASM_SLOT_WIDTH-1:0] number;     // Slot in frame, or in half
    } asm_slot_pos_t;

    typedef struct packed {
        logic data;
        logic enable;
    } asm_line_drive_t;

endpackage : asm_pkg

// >>> src/asm_slot_lane.sv
`timescale 1ns/100ps
module asm_slot_lane
    import asm_pkg::*;
(
    input  wire asm_chan_cfg_t i_cfg,
    input  wire asm_slot_pos_t i_pos,
    output logic               o_hit_primary,
    output logic               o_hit_secondary
);

    // ************************************************************
    // Slot match
    // ************************************************************
    logic hit;

    // TDM compares the full index; the half formats split it at bit 5
    always_comb begin
        if (!i_pos.valid) begin
            hit = 1'b0;
        end else if (i_pos.tdm) begin
            hit = (i_pos.number == i_cfg.slot_index);
        end else begin
            // A half holds only 32 slots, so a position at 32 or above never matches
            hit = !i_pos.number[ASM_HALF_BIT]
                  && (i_cfg.slot_index[ASM_HALF_BIT] == i_pos.right_half)
                  && (i_cfg.slot_index[ASM_HALF_BIT-1:0] == i_pos.number[ASM_HALF_BIT-1:0]);
        end
    end

    // Steer the match to one of the two lines
    assign o_hit_primary   = hit && !i_cfg.line_sel;
    assign o_hit_secondary = hit && i_cfg.line_sel;

endmodule // asm_slot_lane

// >>> sim/asm_slot_mapper_properties.sv
`timescale 1ns/100ps
// ****************************************
// Port checks for the slot mapper
// ****************************************
module asm_slot_mapper_chk
    import asm_pkg::*;
#(
    parameter int CHANNELS = ASM_NUM_CHANNELS
) (
    input wire logic                i_clock,
    input wire logic                i_sys_rst,
    input wire logic [7:0]          i_addr,
    input wire logic [7:0]          i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [7:0]          o_rdata,
    input wire asm_slot_pos_t       i_slot,
    input wire logic                o_primary_serial_oe,
    input wire logic                o_general_pin_one_oe,
    input wire logic [CHANNELS-1:0] o_chan_active
);
    logic [6:0] shad [3];
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // Shadow of the channel registers, so slot checks know the mapping
    always_ff @(posedge i_clock) begin
        for (int c = 0; c < 3; c++) begin
            if (i_sys_rst) shad[c] <= ASM_CHAN_RESETS[c][6:0];
            else if (i_wr && i_addr == ASM_CHAN_ADDRS[c]) shad[c] <= i_wdata[6:0];
        end
    end
    AST_RSVD_ZERO: assert property (i_rd |=> !o_rdata[7])
        else $error("reserved bit read back set");
    AST_CH1_RESET: assert property ($past(i_sys_rst) && i_rd && i_addr == ASM_ADDR_CH1 |=>
        o_rdata == ASM_CH1_RESET) else $error("channel 1 reset value wrong");
    AST_CH2_RESET: assert property ($past(i_sys_rst) && i_rd && i_addr == ASM_ADDR_CH2 |=>
        o_rdata == ASM_CH2_RESET) else $error("channel 2 reset value wrong");
    AST_CH3_RESET: assert property ($past(i_sys_rst) && i_rd && i_addr == ASM_ADDR_CH3 |=>
        o_rdata == ASM_CH3_RESET) else $error("channel 3 reset value wrong");
    AST_LINE_SEL: assert property (i_slot.valid && i_slot.tdm && i_slot.number == shad[0][5:0] |=>
        o_chan_active[0] && ($past(shad[0][6]) ? o_general_pin_one_oe : o_primary_serial_oe))
        else $error("channel 1 on wrong line");
    AST_LEFT_SLOT: assert property (i_slot.valid && !i_slot.tdm && !i_slot.right_half
        && {1'b0, i_slot.number[4:0]} == shad[1][5:0] && !i_slot.number[5] |=> o_chan_active[1])
        else $error("left slot missed");
    AST_RIGHT_SLOT: assert property (i_slot.valid && !i_slot.tdm && i_slot.right_half
        && {1'b1, i_slot.number[4:0]} == shad[2][5:0] && !i_slot.number[5] |=> o_chan_active[2])
        else $error("right slot missed");
    AST_NO_SLOT: assert property (!i_slot.valid |=> o_chan_active == '0 && !o_primary_serial_oe)
        else $error("active outside a slot");
endmodule // asm_slot_mapper_chk

// >>> sim/asm_host_rx.sv
`timescale 1ns/100ps
// ****************************************
// Host receiver on both serial lines
// ****************************************
module asm_host_rx (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_pri,
    input  wire logic       i_pri_oe,
    input  wire logic       i_sec,
    input  wire logic       i_sec_oe,
    output logic      [7:0] o_pri_word,
    output logic      [7:0] o_sec_word
);
    // Shift in only driven bits; an undriven line carries nothing
    // Cleared with the device so the bench never compares unknown history
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pri_word <= 8'h00;
            o_sec_word <= 8'h00;
        end else begin
            if (i_pri_oe) o_pri_word <= {o_pri_word[6:0], i_pri};
            if (i_sec_oe) o_sec_word <= {o_sec_word[6:0], i_sec};
        end
    end
endmodule // asm_host_rx

// >>> sim/tb_top.sv
`timescale 1ns/100ps
// ****************************************
// Slot mapper bench
// ****************************************
module tb_top
    import asm_pkg::*;
;
    logic          i_clock = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0;
    logic [7:0]    i_addr = 0, i_wdata = 0, o_rdata, pw, sw;
    asm_slot_pos_t i_slot = '0, p;
    logic [2:0]    i_chan_bits = 0, o_chan_active;
    logic          po, pe, so, se, o_collision;
    logic [7:0]    cfg [3];
    int            errors = 0, comparisons = 0;
    logic [5:0]    s;
    logic [7:0]    em, pwb, swb;
    asm_slot_mapper asm_slot_mapper_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slot(i_slot),
        .i_chan_bits(i_chan_bits), .o_primary_serial_out(po), .o_primary_serial_oe(pe),
        .o_general_pin_one_out(so), .o_general_pin_one_oe(se), .o_chan_active(o_chan_active),
        .o_collision(o_collision));
    asm_host_rx asm_host_rx_inst (.i_clock(i_clock), .i_rst(i_sys_rst), .i_pri(po), .i_pri_oe(pe), .i_sec(so),
        .i_sec_oe(se), .o_pri_word(pw), .o_sec_word(sw));
    // Free running 200 MHz clock
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic check(input string n, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clock) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clock) i_wr <= 0;
        for (int c = 0; c < 3; c++) if (a == ASM_CHAN_ADDRS[c]) cfg[c] = d & 8'h7F;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge i_clock) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clock) i_rd <= 0;
        #1 check("rdata", o_rdata, exp);
    endtask
    // Expected {active, pri oe, pri data, sec oe, sec data} from the register model
    function automatic logic [7:0] exp_map(asm_slot_pos_t q, logic [2:0] b);
        logic [7:0] e;
        logic h;
        e = 0;
        for (int c = 0; c < 3; c++) begin
            h = q.valid && (q.tdm ? q.number == cfg[c][5:0]
                : !q.number[5] && {q.right_half, q.number[4:0]} == cfg[c][5:0]);
            e[c + 4] = h;
            if (h) e = cfg[c][6] ? e | {6'h0, 1'b1, b[c]} : e | {4'h0, 1'b1, b[c], 2'h0};
        end
        return e;
    endfunction
    // Fixed seed keeps every run identical
    initial begin
        void'($urandom(32'h10c6_e7cb));
        for (int c = 0; c < 3; c++) begin
            @(posedge i_clock) i_sys_rst <= 1;
            repeat (5) @(posedge i_clock);
            {i_sys_rst, i_rd, i_addr} <= {1'b0, 1'b1, ASM_CHAN_ADDRS[c]};
            @(posedge i_clock) i_rd <= 0;
            #1 check("reset", o_rdata, ASM_CHAN_RESETS[c]);
            cfg[c] = ASM_CHAN_RESETS[c];
        end
        $display("test reset values done");
        wr(ASM_ADDR_CH1, 8'hFF);
        rd(ASM_ADDR_CH1, 8'h7F);
        rd(8'h20, 8'h00);
        wr(ASM_ADDR_CH2, 8'h1F);
        wr(ASM_ADDR_CH3, 8'h60);
        $display("test registers done");
        for (int i = 0; i < 400; i++) begin
            if (i % 16 == 15) wr(ASM_CHAN_ADDRS[$urandom % 3], 8'($urandom));
            s = cfg[$urandom % 3][5:0];
            p.valid = ($urandom % 8) != 0;
            p.tdm = 1'($urandom);
            p.right_half = p.tdm ? 1'($urandom) : s[5];
            p.number = (i % 5 == 0) ? 6'($urandom) : p.tdm ? s : {1'b0, s[4:0]};
            @(posedge i_clock) {i_slot, i_chan_bits} <= {p, 3'($urandom)};
            @(posedge i_clock) #1 em = exp_map(i_slot, i_chan_bits);
            check("map", {1'b0, o_chan_active, pe, po, se, so}, em);
            {pwb, swb} = {pw, sw};
            // The host takes the bit one edge after the pins settle, and only while the line is driven
            @(posedge i_clock) #1 check("host primary", pw, em[3] ? {pwb[6:0], em[2]} : pwb);
            check("host secondary", sw, em[1] ? {swb[6:0], em[0]} : swb);
        end
        $display("test slot mapping done");
        // Two channels in one primary slot: flag sets, holds, and a clear loses to a live clash
        wr(ASM_ADDR_CH1, 8'h05);
        wr(ASM_ADDR_CH2, 8'h05);
        wr(ASM_ADDR_CH3, 8'h45);
        @(posedge i_clock) i_slot <= '{1'b1, 1'b1, 1'b0, 6'h05};
        @(posedge i_clock) #1 check("clash", {7'h00, o_collision}, 8'h01);
        rd(ASM_ADDR_STATUS, 8'h0F);
        wr(ASM_ADDR_STATUS, 8'h08);
        #1 check("clash kept", {7'h00, o_collision}, 8'h01);
        @(posedge i_clock) i_slot <= '0;
        repeat (2) @(posedge i_clock);
        #1 check("clash sticky", {7'h00, o_collision}, 8'h01);
        wr(ASM_ADDR_STATUS, 8'h08);
        #1 check("clash cleared", {7'h00, o_collision}, 8'h00);
        rd(ASM_ADDR_STATUS, 8'h00);
        $display("test clash flag done");
        end_sim();
    end
    // Watchdog against a hung run
    initial begin
        #200000 errors++;
        end_sim();
    end
endmodule // tb_top
bind asm_slot_mapper asm_slot_mapper_chk #(.CHANNELS(CHANNELS)) asm_slot_mapper_chk_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_slot(i_slot), .o_primary_serial_oe(o_primary_serial_oe),
    .o_general_pin_one_oe(o_general_pin_one_oe), .o_chan_active(o_chan_active));
